// File: common/uas_pkg.sv
// shared constants and register layouts for the asynchronous serial channel
package uas_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] UAS_OFS_TX_BUF = 8'h00;
  localparam logic [7:0] UAS_OFS_RX_BUF = 8'h04;
  localparam logic [7:0] UAS_OFS_BAUD = 8'h08;
  localparam logic [7:0] UAS_OFS_MODE = 8'h0c;
  localparam logic [7:0] UAS_OFS_CTRL0 = 8'h10;
  localparam logic [7:0] UAS_OFS_CTRL1 = 8'h14;
  localparam logic [7:0] UAS_OFS_SPEC_A = 8'h18;
  localparam logic [7:0] UAS_OFS_SPEC_B = 8'h1c;
  localparam logic [7:0] UAS_OFS_SPEC_C = 8'h20;
  localparam logic [7:0] UAS_OFS_SPEC_D = 8'h24;
  localparam logic [7:0] UAS_OFS_COMMON = 8'h28;
  // ---------------------------------------------------------------
  // mode field codes and frame figures
  // ---------------------------------------------------------------
  localparam logic [2:0] UAS_MODE_7BIT = 3'h4;
  localparam logic [2:0] UAS_MODE_8BIT = 3'h5;
  localparam logic [2:0] UAS_MODE_9BIT = 3'h6;
  localparam logic [3:0] UAS_LEN_7 = 4'h7;
  localparam logic [3:0] UAS_LEN_8 = 4'h8;
  localparam logic [3:0] UAS_LEN_9 = 4'h9;
  localparam logic [3:0] UAS_OVS_LAST = 4'hf;
  localparam logic [3:0] UAS_OVS_MID = 4'h7;
  localparam int UAS_TXIRQ_SRC_BIT = 4;
  localparam int UAS_ALT_CTS_BIT = 6;
  localparam logic [4:0] UAS_PRE_F8 = 5'h07;
  localparam logic [4:0] UAS_PRE_F32 = 5'h1f;
  localparam logic [7:0] UAS_CTRL0_RST = 8'h08;
  localparam logic [7:0] UAS_CTRL1_RST = 8'h02;
  // ---------------------------------------------------------------
  // register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pinPolarityInvert;
    logic parityEnable;
    logic parityOddEven;
    logic stopBitCountSelect;
    logic clockSourceInternalExternal;
    logic [2:0] serialModeField;
  } uas_mode_t;
  typedef struct packed {
    logic bitOrderSelect;
    logic clockPolaritySelect;
    logic openDrainOutputSelect;
    logic flowControlDisable;
    logic shiftRegisterEmpty;
    logic flowPinFunctionSelect;
    logic [1:0] prescalerSelect;
  } uas_ctrl0_t;
  typedef struct packed {
    logic errorSignalEnable;
    logic dataLogicInvert;
    logic continuousReceive;
    logic ch2TxIrqSource;
    logic receiveComplete;
    logic receiveEnableBit;
    logic transmitBufferEmpty;
    logic transmitEnableBit;
  } uas_ctrl1_t;
  typedef struct packed {
    logic errorSum;
    logic parityFlag;
    logic framingFlag;
    logic overrunFlag;
    logic [2:0] zero;
    logic [8:0] data;
  } uas_rxbuf_t;
  typedef enum logic [1:0] {UAS_IDLE, UAS_FRAME} uas_state_t;
endpackage : uas_pkg

// File: rtl/uas_channel.sv
// one asynchronous serial channel with apb registers
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module uas_channel import uas_pkg::*; #(
  parameter int CHANNEL = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxdIn,
  output logic txdOut,
  output logic txdOen_n,
  input wire logic extClkIn,
  input wire logic flowIn_n,
  input wire logic altCtsIn_n,
  output logic flowOut,
  output logic flowOen_n,
  output logic txIrq,
  output logic rxIrq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  uas_mode_t mode_reg;
  uas_ctrl0_t ctrl0_reg;
  uas_ctrl1_t ctrl1_reg;
  logic [7:0] baud_reg, common_reg;
  logic [7:0] specA_reg, specB_reg, specC_reg, specD_reg;
  logic [8:0] txBuf_reg, txShift_reg, rxData_reg, rxShift_reg;
  logic overrun_reg, framing_reg, parity_reg, txEmpty_reg;
  logic [31:0] rdData;
  logic wrAcc, rdAcc, mapped, rxCopy;
  logic asyncOn, msbFirst, invData, invPin, txIrqSrc, ctsLow, txStart;
  logic [3:0] charLen, lastPos;
  uas_rxbuf_t rxView;

  always_comb begin
    asyncOn = 1'b1;
    charLen = UAS_LEN_8;
    case (mode_reg.serialModeField)
      UAS_MODE_7BIT: charLen = UAS_LEN_7;
      UAS_MODE_8BIT: charLen = UAS_LEN_8;
      UAS_MODE_9BIT: charLen = UAS_LEN_9;
      default: asyncOn = 1'b0;
    endcase
  end

  // last frame position: data + parity + stops, with the start bit at position 0
  assign lastPos = charLen + 4'(mode_reg.parityEnable) + 4'(mode_reg.stopBitCountSelect) + 4'h1;
  assign msbFirst = ctrl0_reg.bitOrderSelect;
  assign invData = (CHANNEL == 2) && ctrl1_reg.dataLogicInvert;
  assign invPin = (CHANNEL == 2) && mode_reg.pinPolarityInvert;
  assign txIrqSrc = (CHANNEL == 2) ? ctrl1_reg.ch2TxIrqSource : common_reg[CHANNEL];

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    rxView = '0;
    rxView.data = rxData_reg ^ {9{invData}};
    rxView.overrunFlag = overrun_reg;
    rxView.framingFlag = framing_reg;
    rxView.parityFlag = parity_reg;
    rxView.errorSum = overrun_reg | framing_reg | parity_reg;
    mapped = 1'b1;
    rdData = '0;
    case (paddr)
      UAS_OFS_TX_BUF: rdData = '0;
      UAS_OFS_RX_BUF: rdData = {16'h0000, rxView};
      UAS_OFS_BAUD: rdData = '0;
      UAS_OFS_MODE: rdData = {24'h000000, mode_reg};
      UAS_OFS_CTRL0: rdData = {24'h000000, ctrl0_reg};
      UAS_OFS_CTRL1: rdData = {24'h000000, ctrl1_reg};
      UAS_OFS_SPEC_A: rdData = {24'h000000, specA_reg};
      UAS_OFS_SPEC_B: rdData = {24'h000000, specB_reg};
      UAS_OFS_SPEC_C: rdData = {24'h000000, specC_reg};
      UAS_OFS_SPEC_D: rdData = {24'h000000, specD_reg};
      UAS_OFS_COMMON: rdData = {24'h000000, common_reg};
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? '0 : rdData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= '0;
      baud_reg <= '0;
      common_reg <= '0;
      specA_reg <= '0;
      specB_reg <= '0;
      specC_reg <= '0;
      specD_reg <= '0;
    end else if (wrAcc) begin
      case (paddr)
        UAS_OFS_MODE: mode_reg <= pwdata[7:0];
        UAS_OFS_BAUD: baud_reg <= pwdata[7:0];
        UAS_OFS_COMMON: common_reg <= pwdata[7:0];
        UAS_OFS_SPEC_A: specA_reg <= pwdata[7:0];
        UAS_OFS_SPEC_B: specB_reg <= pwdata[7:0];
        UAS_OFS_SPEC_C: specC_reg <= pwdata[7:0];
        UAS_OFS_SPEC_D: specD_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bit clock
  // ---------------------------------------------------------------
  logic [4:0] pre_reg;
  logic [7:0] baudCnt_reg;
  logic extPrev_reg, srcTick, ovsTick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
      extPrev_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 5'h01;
      extPrev_reg <= extClkIn;
    end
  end

  // count source: f1, f2, f8, f32 or external rising edge
  always_comb begin
    case (ctrl0_reg.prescalerSelect)
      2'h0: srcTick = 1'b1;
      2'h1: srcTick = pre_reg[0];
      2'h2: srcTick = (pre_reg[2:0] == UAS_PRE_F8[2:0]);
      default: srcTick = (pre_reg == UAS_PRE_F32);
    endcase
    if (mode_reg.clockSourceInternalExternal) begin
      srcTick = extClkIn && !extPrev_reg;
    end
  end

  // divide by n+1 here, by 16 in the shifters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baudCnt_reg <= '0;
    end else if (!asyncOn) begin
      baudCnt_reg <= baud_reg;
    end else if (srcTick) begin
      baudCnt_reg <= (baudCnt_reg == 8'h00) ? baud_reg : baudCnt_reg - 8'h01;
    end
  end

  assign ovsTick = asyncOn && srcTick && (baudCnt_reg == 8'h00);

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  uas_state_t txState_reg;
  logic [3:0] txPos_reg, txSub_reg;
  logic txLine, txPar, txDone;
  logic [3:0] txIdx;

  // cts only when flow on and cts selected
  assign ctsLow = ctrl0_reg.flowControlDisable || ctrl0_reg.flowPinFunctionSelect ||
                  ((CHANNEL == 0 && common_reg[UAS_ALT_CTS_BIT]) ? !altCtsIn_n : !flowIn_n);
  assign txStart = asyncOn && txState_reg == UAS_IDLE && ctrl1_reg.transmitEnableBit &&
                   !ctrl1_reg.transmitBufferEmpty && ctsLow;
  assign txDone = txState_reg == UAS_FRAME && ovsTick && txSub_reg == UAS_OVS_LAST &&
                  txPos_reg == lastPos;
  assign txPar = (^(txShift_reg & ~(9'h1ff << charLen))) ^ ~mode_reg.parityOddEven;
  assign txIdx = msbFirst ? (charLen - txPos_reg) : (txPos_reg - 4'h1);

  always_comb begin
    txLine = 1'b1;
    if (txState_reg == UAS_FRAME) begin
      if (txPos_reg == 4'h0) begin
        txLine = 1'b0;
      end else if (txPos_reg <= charLen) begin
        txLine = txShift_reg[txIdx];
      end else if (txPos_reg == charLen + 4'h1 && mode_reg.parityEnable) begin
        txLine = txPar;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_reg <= UAS_IDLE;
      txPos_reg <= '0;
      txSub_reg <= '0;
      txShift_reg <= '0;
    end else begin
      case (txState_reg)
        UAS_IDLE: if (txStart) begin
          txState_reg <= UAS_FRAME;
          txShift_reg <= txBuf_reg ^ {9{invData}};
          txPos_reg <= '0;
          txSub_reg <= '0;
        end
        UAS_FRAME: if (!asyncOn) begin
          txState_reg <= UAS_IDLE;
        end else if (ovsTick) begin
          txSub_reg <= txSub_reg + 4'h1;
          if (txSub_reg == UAS_OVS_LAST) begin
            txPos_reg <= txPos_reg + 4'h1;
            if (txDone) begin
              txState_reg <= UAS_IDLE;
            end
          end
        end
        default: txState_reg <= UAS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBuf_reg <= '0;
      txEmpty_reg <= 1'b1;
      txIrq <= 1'b0;
      ctrl1_reg <= UAS_CTRL1_RST;
    end else begin
      txIrq <= (txStart && !txIrqSrc) || (txDone && txIrqSrc);
      if (txStart) begin
        ctrl1_reg.transmitBufferEmpty <= 1'b1;
        txEmpty_reg <= 1'b0;
      end else if (txDone) begin
        txEmpty_reg <= 1'b1;
      end
      if (wrAcc && paddr == UAS_OFS_TX_BUF) begin
        txBuf_reg <= pwdata[8:0];
        ctrl1_reg.transmitBufferEmpty <= 1'b0;
      end
      if (wrAcc && paddr == UAS_OFS_CTRL1) begin
        {ctrl1_reg.errorSignalEnable, ctrl1_reg.dataLogicInvert} <= pwdata[7:6];
        {ctrl1_reg.continuousReceive, ctrl1_reg.ch2TxIrqSource} <= pwdata[5:4];
        ctrl1_reg.receiveEnableBit <= pwdata[2];
        ctrl1_reg.transmitEnableBit <= pwdata[0];
      end
      // set wins over the read clear
      if (rxCopy) begin
        ctrl1_reg.receiveComplete <= 1'b1;
      end else if (rdAcc && paddr == UAS_OFS_RX_BUF) begin
        ctrl1_reg.receiveComplete <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_reg <= UAS_CTRL0_RST;
    end else begin
      if (wrAcc && paddr == UAS_OFS_CTRL0) begin
        ctrl0_reg <= pwdata[7:0];
      end
      ctrl0_reg.shiftRegisterEmpty <= txEmpty_reg;
    end
  end

  always_comb begin
    if (ctrl0_reg.openDrainOutputSelect) begin
      txdOut = 1'b0;
      txdOen_n = (txLine ^ invPin);
    end else begin
      txdOut = txLine ^ invPin;
      txdOen_n = 1'b0;
    end
  end

  // rts low while receiver can take a character
  assign flowOut = !(ctrl1_reg.receiveEnableBit && !ctrl1_reg.receiveComplete);
  assign flowOen_n = !(!ctrl0_reg.flowControlDisable && ctrl0_reg.flowPinFunctionSelect);

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  uas_state_t rxState_reg;
  logic [3:0] rxPos_reg, rxSub_reg, rxIdx;
  logic rxLine, rxSample, rxPar_reg, rxFrm_reg, rxOvr_reg;

  assign rxLine = rxdIn ^ invPin;
  assign rxSample = rxState_reg == UAS_FRAME && ovsTick && rxSub_reg == UAS_OVS_MID;
  assign rxCopy = rxSample && rxPos_reg == lastPos;
  assign rxIdx = msbFirst ? (charLen - rxPos_reg) : (rxPos_reg - 4'h1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_reg <= UAS_IDLE;
      rxPos_reg <= '0;
      rxSub_reg <= '0;
      rxShift_reg <= '0;
      rxPar_reg <= 1'b0;
      rxFrm_reg <= 1'b0;
      rxOvr_reg <= 1'b0;
    end else begin
      case (rxState_reg)
        UAS_IDLE: if (ovsTick && !rxLine && ctrl1_reg.receiveEnableBit) begin
          rxState_reg <= UAS_FRAME;
          rxPos_reg <= '0;
          rxSub_reg <= '0;
          rxShift_reg <= '0;
          rxPar_reg <= ~mode_reg.parityOddEven;
          rxFrm_reg <= 1'b0;
          rxOvr_reg <= 1'b0;
        end
        UAS_FRAME: if (!asyncOn || !ctrl1_reg.receiveEnableBit) begin
          rxState_reg <= UAS_IDLE;
        end else if (ovsTick) begin
          rxSub_reg <= rxSub_reg + 4'h1;
          if (rxSub_reg == UAS_OVS_LAST) begin
            rxPos_reg <= rxPos_reg + 4'h1;
          end
          if (rxSample) begin
            if (rxPos_reg == 4'h0 && rxLine) begin
              rxState_reg <= UAS_IDLE; // glitch, not a start bit
            end else if (rxPos_reg != 4'h0 && rxPos_reg <= charLen) begin
              rxShift_reg[rxIdx] <= rxLine;
              rxPar_reg <= rxPar_reg ^ rxLine;
            end else if (rxPos_reg == charLen + 4'h1 && mode_reg.parityEnable) begin
              rxPar_reg <= rxPar_reg ^ rxLine;
            end else if (rxPos_reg != 4'h0) begin
              rxFrm_reg <= rxFrm_reg | !rxLine;
            end
            if (rxPos_reg == lastPos - 4'h1 && ctrl1_reg.receiveComplete) begin
              rxOvr_reg <= 1'b1;
            end
            if (rxCopy) begin
              rxState_reg <= UAS_IDLE;
            end
          end
        end
        default: rxState_reg <= UAS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxData_reg <= '0;
      overrun_reg <= 1'b0;
      framing_reg <= 1'b0;
      parity_reg <= 1'b0;
      rxIrq <= 1'b0;
    end else begin
      rxIrq <= rxCopy && !rxOvr_reg;
      if (rxCopy) begin
        rxData_reg <= rxShift_reg; // overwritten data is undefined
        overrun_reg <= rxOvr_reg;
        framing_reg <= rxFrm_reg | !rxLine;
        parity_reg <= mode_reg.parityEnable && rxPar_reg;
      end else if (!ctrl1_reg.receiveEnableBit) begin
        overrun_reg <= 1'b0;
        framing_reg <= 1'b0;
        parity_reg <= 1'b0;
      end
    end
  end
endmodule : uas_channel

// File: test/uas_channel_sva.sv
// port assertions for the asynchronous serial channel
`timescale 1ns/100ps
module uas_channel_sva import uas_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic txdOut,
  input wire logic txdOen_n,
  input wire logic flowIn_n,
  input wire logic txIrq,
  input wire logic rxIrq
);
  logic [7:0] modeQ, ctrl0Q, ctrl1Q, idleCnt;
  logic lvl, rdRx;
  // ----------
  // register shadows, idle run of the line
  // ----------
  assign lvl = (txdOen_n ? 1'b1 : txdOut) ^ modeQ[7];
  assign rdRx = psel && penable && !pwrite && paddr == UAS_OFS_RX_BUF;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeQ <= 8'h00;
      ctrl0Q <= 8'h08;
      ctrl1Q <= 8'h02;
    end else if (psel && penable && pwrite) begin
      if (paddr == UAS_OFS_MODE) modeQ <= pwdata[7:0];
      if (paddr == UAS_OFS_CTRL0) ctrl0Q <= pwdata[7:0];
      if (paddr == UAS_OFS_CTRL1) ctrl1Q <= pwdata[7:0];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) idleCnt <= 8'h00;
    else if (!lvl) idleCnt <= 8'h00;
    else if (idleCnt != 8'hff) idleCnt <= idleCnt + 8'h01;
  end
  // ----------
  // properties
  // ----------
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // longer than any high run inside a frame at divider 0 and f1 (at most 12 bits of 16 cycles)
  sequence lineIdle;
    idleCnt >= 8'hc8;
  endsequence
  sequence stopDone;
    lvl && idleCnt >= 8'h08;
  endsequence
  AST_TXIRQ_START: assert property (txIrq && !ctrl1Q[4] |-> !lvl)
    else $error("tx irq on source 0 outside start bit");
  AST_TXIRQ_END: assert property (txIrq && ctrl1Q[4] |-> stopDone)
    else $error("tx irq on source 1 before stop bit done");
  AST_TXIRQ_PULSE: assert property (txIrq |=> !txIrq)
    else $error("tx irq longer than one cycle");
  AST_RXIRQ_PULSE: assert property (rxIrq |=> !rxIrq)
    else $error("rx irq longer than one cycle");
  AST_RX_NEEDS_EN: assert property (!ctrl1Q[2] |-> !rxIrq)
    else $error("rx irq while reception disabled");
  AST_TX_NEEDS_EN: assert property (lineIdle and !ctrl1Q[0] |-> lvl)
    else $error("frame started while transmission disabled");
  AST_TX_NEEDS_CTS: assert property (lineIdle and !ctrl0Q[4] && !ctrl0Q[2] && flowIn_n |-> lvl)
    else $error("frame started while clear to send inactive");
  AST_OD_DRIVE: assert property (ctrl0Q[5] ? !txdOut : !txdOen_n)
    else $error("transmit pin drive mode wrong");
  AST_RXBUF_SUM: assert property (rdRx |-> prdata[15] == |prdata[14:12])
    else $error("error sum does not match flags");
  AST_RXBUF_ZERO: assert property (rdRx |-> prdata[31:16] == 16'h0000 && prdata[11:9] == 3'h0)
    else $error("receive buffer unused bits set");
endmodule : uas_channel_sva
bind uas_channel uas_channel_sva chk_u (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .txdOut(txdOut), .txdOen_n(txdOen_n), .flowIn_n(flowIn_n), .txIrq(txIrq), .rxIrq(rxIrq));

// File: test/uas_remote_model.sv
// remote serial party: captures and sends frames at 16 cycles a bit
`timescale 1ns/100ps
module uas_remote_model (
  input wire logic clk,
  input wire logic txLine,
  input wire logic polInv,
  input wire logic ctsHold,
  output logic rxLine,
  output logic ctsOut_n
);
  logic [11:0] gotBits;
  logic rxBit = 1'b1;
  int nGot = 0;
  assign ctsOut_n = ctsHold;
  assign rxLine = rxBit ^ polInv;
  // start must still be low at mid bit, else it was a glitch
  always begin
    @(posedge clk);
    if ((txLine ^ polInv) === 1'b0) begin
      repeat (7) @(posedge clk);
      if ((txLine ^ polInv) === 1'b0) begin
        for (int i = 0; i < 12; i++) begin
          repeat (16) @(posedge clk);
          gotBits[i] = txLine ^ polInv;
        end
        nGot++;
      end
    end
  end
  task automatic send_frame(input logic [11:0] bits);
    rxBit <= 1'b0;
    repeat (16) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      rxBit <= bits[i];
      repeat (16) @(posedge clk);
    end
    rxBit <= 1'b1;
    repeat (16) @(posedge clk);
  endtask : send_frame
endmodule : uas_remote_model

// File: test/uas_channel_tb.sv
// self-checking bench for the asynchronous serial channel
`timescale 1ns/100ps
module uas_channel_tb import uas_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdQ;
  logic pready, pslverr, errQ, txdOut, txdOen_n, txIrq, rxIrq, rxLine, ctsN, txLine;
  logic polInv = 1'b0, ctsHold = 1'b0;
  logic flowOut, flowOen_n;
  int n_mismatch = 0, n_compared = 0, nCyc = 0, nRxIrq = 0, nTxIrq = 0, nLow = 0;
  // msb first only on 8 bits, unused async settings kept zero
  logic [7:0] tMode [6] = '{8'h04, 8'h65, 8'h56, 8'h05, 8'h85, 8'h65};
  logic [7:0] tC0 [6] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h30};
  logic [7:0] tC1 [6] = '{8'h05, 8'h05, 8'h15, 8'h05, 8'h45, 8'h05};
  logic [8:0] tData [6] = '{9'h05a, 9'h0a5, 9'h1c3, 9'h0b1, 9'h036, 9'h0ff};
  assign txLine = txdOen_n ? 1'b1 : txdOut;
  always #4 clk = ~clk;
  uas_channel dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxdIn(rxLine), .txdOut(txdOut), .txdOen_n(txdOen_n),
    .extClkIn(1'b0), .flowIn_n(ctsN), .altCtsIn_n(1'b1), .flowOut(flowOut),
    .flowOen_n(flowOen_n),
    .txIrq(txIrq), .rxIrq(rxIrq));
  uas_remote_model remote_u (.clk(clk), .txLine(txLine), .polInv(polInv),
    .ctsHold(ctsHold), .rxLine(rxLine), .ctsOut_n(ctsN));
  always @(posedge clk) begin
    nCyc <= nCyc + 1;
    if (rxIrq === 1'b1) nRxIrq <= nRxIrq + 1;
    if (txIrq === 1'b1) nTxIrq <= nTxIrq + 1;
    if (txLine === 1'b0) nLow <= nLow + 1;
    if (nCyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ----------
  // bus and compare tasks
  // ----------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdQ = prdata;
    errQ = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input string what);
    apb(1'b0, a, 32'h0);
    chk(what, e, rdQ & m);
  endtask : rdchk
  task automatic wait_got(input int n0);
    repeat (600) if (remote_u.nGot == n0) @(posedge clk);
  endtask : wait_got
  function automatic logic [11:0] mk_frame(input logic [7:0] md, input logic [7:0] c0,
      input logic [7:0] c1, input logic [8:0] d);
    logic [11:0] f;
    logic [8:0] s;
    logic p;
    int n;
    f = 12'hfff;
    s = c1[6] ? ~d : d;
    p = 1'b0;
    n = md[2:0] + 3;
    for (int i = 0; i < n; i++) begin
      f[i] = c0[7] ? s[7 - i] : s[i];
      p ^= f[i];
    end
    if (md[6]) f[n] = md[5] ? p : ~p;
    return f;
  endfunction : mk_frame
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ----------
  // main sequence
  // ----------
  initial begin
    logic [11:0] f;
    logic [8:0] dm;
    int n0, t0, r0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(UAS_OFS_CTRL0, 32'hffffffff, 32'h08, "ctrl0 reset");
    rdchk(UAS_OFS_CTRL1, 32'hffffffff, 32'h02, "ctrl1 reset");
    wr(UAS_OFS_BAUD, 32'h00);
    rdchk(UAS_OFS_BAUD, 32'hffffffff, 32'h0, "baud readback");
    rdchk(8'h2c, 32'hffffffff, 32'h0, "unmapped data");
    chk("unmapped error", 32'h1, errQ);
    for (int k = 0; k < 6; k++) begin
      wr(UAS_OFS_MODE, tMode[k]);
      polInv <= tMode[k][7];
      wr(UAS_OFS_CTRL0, tC0[k]);
      wr(UAS_OFS_CTRL1, tC1[k]);
      f = mk_frame(tMode[k], tC0[k], tC1[k], tData[k]);
      dm = 9'h1ff >> (3'h6 - tMode[k][2:0]);
      n0 = remote_u.nGot;
      t0 = nTxIrq;
      wr(UAS_OFS_TX_BUF, tData[k]);
      repeat (600) if (nTxIrq == t0) @(posedge clk);
      chk("frames at tx irq", tC1[k][4] ? n0 + 1 : n0, remote_u.nGot);
      wait_got(n0);
      chk("tx frame", f, remote_u.gotBits);
      r0 = nRxIrq;
      remote_u.send_frame(f);
      chk("rx irq", r0 + 1, nRxIrq);
      rdchk(UAS_OFS_RX_BUF, {16'h0, 4'hf, 3'h0, dm}, {23'h0, tData[k] & dm}, "rx data");
    end
    wr(UAS_OFS_CTRL0, 32'h00);
    f = mk_frame(8'h65, 8'h00, 8'h05, 9'h0a5);
    remote_u.send_frame(f ^ 12'h100);
    rdchk(UAS_OFS_RX_BUF, 32'hf000, 32'hc000, "parity flags");
    remote_u.send_frame(f & 12'hdff);
    rdchk(UAS_OFS_RX_BUF, 32'hf000, 32'ha000, "framing flags");
    r0 = nRxIrq;
    remote_u.send_frame(f);
    rdchk(UAS_OFS_CTRL1, 32'h08, 32'h08, "receive complete");
    remote_u.send_frame(f);
    chk("rx irq on overrun", r0 + 1, nRxIrq);
    rdchk(UAS_OFS_RX_BUF, 32'hf000, 32'h9000, "overrun flags");
    n0 = remote_u.nGot;
    ctsHold <= 1'b1;
    wr(UAS_OFS_CTRL1, 32'h04);
    wr(UAS_OFS_TX_BUF, 32'h03c);
    repeat (64) @(posedge clk);
    rdchk(UAS_OFS_CTRL1, 32'h02, 32'h00, "buffer kept while tx disabled");
    wr(UAS_OFS_CTRL1, 32'h05);
    repeat (64) @(posedge clk);
    rdchk(UAS_OFS_CTRL1, 32'h02, 32'h00, "buffer kept while cts high");
    ctsHold <= 1'b0;
    wait_got(n0);
    chk("released frame", mk_frame(8'h65, 8'h00, 8'h05, 9'h03c), remote_u.gotBits);
    wr(UAS_OFS_CTRL0, 32'h04);
    chk("rts ready", 32'h0, {flowOen_n, flowOut});
    wr(UAS_OFS_CTRL1, 32'h01);
    r0 = nRxIrq;
    remote_u.send_frame(f);
    chk("rx irq while disabled", r0, nRxIrq);
    chk("rts while rx off", 32'h1, {flowOen_n, flowOut});
    // divider 1: start bit plus data bit 0 low for about 64 cycles
    wr(UAS_OFS_BAUD, 32'h01);
    t0 = nLow;
    wr(UAS_OFS_TX_BUF, 32'h0fe);
    repeat (400) @(posedge clk);
    chk("low cycles over two", 32'd32, (nLow - t0 + 1) / 2);
    report_and_stop();
  end
endmodule : uas_channel_tb
